// ### rtl/vscr_regs.sv
// status and control register pair with its serial exchange
// What this block does
// R1: status request runs one status/control byte swap
// R2: exchange moves eight bits, msb first, device clocks
// R3: end-of-data flag set on ifr byte transfer
// R4: multi-byte flag from control bit or long normalisation
// R5: multi-byte status copy follows data transfers only
// R6: status bit 5 always reads zero
// R7: first-time-up high only in first exchange
// R8: quad status mirrors control, cleared by break end
// R9: codec speed changes only on bus edge
// R10: crc flag set on error, cleared after exchange
// R11: bus faults set the error flag
// R12: host timing faults set the error flag
// R13: error flag cleared by reset and exchange end
// R14: break flag on first rise after break symbol
// R15: host re-arbitrates after break once idle
// R16: control byte layout, sticky host-set bits, reset clear
// R17: response request sends ifr, cleared by success/idle
// R18: response bits accepted until 135 us after crc
// R19: host uses long ready for single-byte response
// R20: single response once; multi-byte suspends after loss
// R21: multi-byte response gets crc appended
// R22: multi-byte bit clears at idle after response
// R23: skip-to-idle holds idle high 6 us, waits idle
// R24: ready still high at transfer end means last
// R25: divide select yields the 2 MHz time base
// R26: flags clear only after their set value shifted out
`timescale 1ns/1ps
`default_nettype none
module vscr_regs #(
  parameter int unsigned RESP_WIN_CYCLES = vscr_pkg::RESP_WIN_CYC
) (
  input  wire  logic                    clk,
  input  wire  logic                    rst,
  input  wire  logic                    stat_req,
  input  wire  logic                    rdy,
  input  wire  logic                    bus_symbol_in,
  input  wire  logic                    sin,
  input  wire  vscr_pkg::vscr_link_ev_t ev,
  output vscr_pkg::vscr_link_ctl_t      lc,
  output vscr_pkg::vscr_stat_t          link_status_byte,
  output vscr_pkg::vscr_ctrl_t          link_control_byte,
  output logic                          sck,
  output logic                          sck_oe_n,
  output logic                          sout,
  output logic                          sout_oe_n,
  output logic                          sactive_n
);

  vscr_pkg::vscr_regs_st_t st_ff;
  vscr_pkg::vscr_regs_st_t nxt_st;

  vscr_pkg::vscr_stat_t status_now;
  vscr_pkg::vscr_ctrl_t rx_ctrl;
  logic [7:0]           rx_byte;
  logic                 sh_busy;
  logic                 sh_done;
  logic                 xch_start;
  logic                 xch_end;
  logic                 stat_rise;
  logic                 bus_rise;
  logic                 bus_edge;
  logic                 brk_end;
  logic [4:0]           div_now;

  assign stat_rise = st_ff.stat_q[1] & ~st_ff.stat_prev;
  assign bus_rise  = st_ff.bus_q[1] & ~st_ff.bus_prev;
  assign bus_edge  = st_ff.bus_q[1] ^ st_ff.bus_prev;
  assign brk_end   = bus_rise & st_ff.brk_armed;
  assign xch_end   = sh_done & st_ff.xch_active;
  assign rx_ctrl   = vscr_pkg::vscr_ctrl_t'(rx_byte);

  // time base runs at the safe divide until software has set a divide
  assign div_now = st_ff.configured ? vscr_pkg::vscr_div_value(st_ff.ctrl.ds)
                                    : vscr_pkg::RESET_DIV; // R25

  // the status word presented to the host
  always_comb begin
    status_now        = '0;
    status_now.end_of_data_flag    = st_ff.end_of_data_flag;
    status_now.multi_byte_response_flag   = st_ff.multi_byte_response_flag;
    status_now.unused = 1'b0; // R6
    status_now.first_power_up_flag    = st_ff.first_power_up_flag;
    status_now.quad   = st_ff.ctrl.quad; // R8
    status_now.crc    = st_ff.crc;
    status_now.err    = st_ff.err;
    status_now.break_flag    = st_ff.break_flag;
  end

  // an exchange waits for any data byte transfer to finish
  assign xch_start = st_ff.pend & ~sh_busy & ~ev.data_xfer_busy & ~st_ff.xch_active; // R1

  always_comb begin
    nxt_st = st_ff;

    // two flops on every pin input
    nxt_st.stat_q    = {st_ff.stat_q[0], stat_req};
    nxt_st.rdy_q     = {st_ff.rdy_q[0], rdy};
    nxt_st.bus_q     = {st_ff.bus_q[0], bus_symbol_in};
    nxt_st.sin_q     = {st_ff.sin_q[0], sin};
    nxt_st.stat_prev = st_ff.stat_q[1];
    nxt_st.bus_prev  = st_ff.bus_q[1];

    // time base divider
    if (st_ff.div_cnt >= div_now - 5'h01) begin
      nxt_st.div_cnt = 5'h00;
      nxt_st.tb_tick = 1'b1; // R25
    end else begin
      nxt_st.div_cnt = st_ff.div_cnt + 5'h01;
      nxt_st.tb_tick = 1'b0;
    end

    // status request handshake
    if (stat_rise) begin
      nxt_st.pend = 1'b1; // R1
    end
    if (xch_start) begin
      nxt_st.pend       = 1'b0;
      nxt_st.xch_active = 1'b1;
      nxt_st.snap       = status_now;
    end

    // flags cleared by a finished exchange drop only the bits that were sent
    if (xch_end) begin
      nxt_st.xch_active = 1'b0;
      nxt_st.configured = 1'b1;
      nxt_st.first_power_up_flag        = 1'b0; // R7
      if (st_ff.snap.crc) begin
        nxt_st.crc = 1'b0; // R10 R26
      end
      if (st_ff.snap.err) begin
        nxt_st.err = 1'b0; // R13 R26
      end
      if (st_ff.snap.break_flag) begin
        nxt_st.break_flag = 1'b0; // R14 R26
      end
    end

    // end-of-data flag follows unsolicited data transfers
    if (ev.data_xfer_start && ev.xfer_first_of_frame && !ev.xfer_is_ifr) begin
      nxt_st.end_of_data_flag = 1'b0; // R3
    end
    if (ev.data_xfer_start && ev.xfer_is_ifr) begin
      nxt_st.end_of_data_flag = 1'b1; // R3
    end

    // multi-byte status copy lags the control bit until a data transfer ends
    if (ev.data_xfer_start && ev.xfer_first_of_frame) begin
      nxt_st.multi_byte_response_flag = 1'b0; // R4
    end
    if ((ev.data_xfer_done && st_ff.ctrl.multi_byte_response_flag) || ev.long_nb_after_eod) begin
      nxt_st.multi_byte_response_flag = 1'b1; // R4 R5
    end

    // ready level at the end of a transfer marks the last byte
    if (ev.data_xfer_done) begin
      nxt_st.rdy_long = st_ff.rdy_q[1]; // R24
    end

    // sticky error flags; a set in the clearing cycle wins
    if (ev.crc_error) begin
      nxt_st.crc = 1'b1; // R10
    end
    if (ev.symbol_error || ev.short_byte || ev.frame_width_error || ev.echo_fail) begin
      nxt_st.err = 1'b1; // R11
    end
    if (ev.host_late_start || ev.missing_long_rdy || (stat_rise && ev.data_xfer_busy)) begin
      nxt_st.err = 1'b1; // R12
    end

    // break flag waits for the bus to come back
    if (ev.break_symbol) begin
      nxt_st.brk_armed = 1'b1;
    end
    if (brk_end) begin
      nxt_st.break_flag       = 1'b1; // R14
      nxt_st.brk_armed = 1'b0;
    end

    // response window after the message crc byte
    if (ev.crc_byte_done) begin
      nxt_st.win_open = 1'b1;
      nxt_st.win_cnt  = vscr_pkg::RESP_CNT_W'(RESP_WIN_CYCLES - 1); // R18
    end else if (st_ff.win_cnt != '0) begin
      nxt_st.win_cnt = st_ff.win_cnt - vscr_pkg::RESP_CNT_W'(1);
    end else if (ev.idle_start) begin
      nxt_st.win_open = 1'b1;
    end else if (st_ff.win_open && st_ff.win_cnt == '0 && st_ff.resp_tx_seen == 1'b0 &&
                 ev.idle_pin_low == 1'b0 && st_ff.end_of_data_flag) begin
      nxt_st.win_open = 1'b0; // R18
    end

    // response progress bookkeeping
    if (ev.resp_tx_start) begin
      nxt_st.resp_tx_seen = 1'b1;
    end
    if (ev.resp_arb_lost && st_ff.ctrl.multi_byte_response_flag) begin
      nxt_st.resp_suspend = 1'b1; // R20
    end
    if (ev.idle_start) begin
      nxt_st.resp_tx_seen = 1'b0;
      nxt_st.resp_suspend = 1'b0;
    end

    // hardware clears of the host-set control bits
    if (ev.resp_tx_ok || ev.idle_start) begin
      nxt_st.ctrl.ack = 1'b0; // R17 R20
    end
    if (ev.idle_start && st_ff.resp_tx_seen) begin
      nxt_st.ctrl.multi_byte_response_flag = 1'b0; // R22
    end
    if (!st_ff.bus_q[1] || stat_rise || st_ff.rdy_q[1]) begin
      nxt_st.ctrl.pd = 1'b0;
    end

    // control byte captured from the host; sticky bits only set here
    if (xch_end) begin
      if (st_ff.win_open) begin
        nxt_st.ctrl.ack  = nxt_st.ctrl.ack | rx_ctrl.ack; // R16 R18
        nxt_st.ctrl.multi_byte_response_flag = nxt_st.ctrl.multi_byte_response_flag | rx_ctrl.multi_byte_response_flag; // R16 R18
      end
      nxt_st.ctrl.nxt = st_ff.ctrl.nxt | rx_ctrl.nxt; // R16
      nxt_st.ctrl.pd  = nxt_st.ctrl.pd | rx_ctrl.pd; // R16
      nxt_st.ctrl.ds  = rx_ctrl.ds; // R16
      // speed bit only changes on an idle bus or in the first exchange
      if (ev.idle_pin_low || !st_ff.configured) begin
        nxt_st.ctrl.quad = rx_ctrl.quad & ~st_ff.snap.break_flag; // R16
      end
    end

    // end of a break drops quad speed
    if (brk_end) begin
      nxt_st.ctrl.quad = 1'b0; // R8 R14
    end

    // codec speed follows the control bit only at a bus edge
    if (bus_edge) begin
      nxt_st.codec_quad = st_ff.ctrl.quad; // R9
    end
    if (brk_end) begin
      nxt_st.codec_quad = 1'b0; // R14
    end

    // skip-to-idle sequence
    unique case (st_ff.skip)
      vscr_pkg::SK_OFF: begin
        if (xch_end && rx_ctrl.nxt) begin
          nxt_st.skip     = vscr_pkg::SK_HOLD; // R23
          nxt_st.skip_cnt = vscr_pkg::SKIP_CNT_W'(vscr_pkg::SKIP_HOLD_CYC - 1);
        end
      end
      vscr_pkg::SK_HOLD: begin
        if (st_ff.skip_cnt != '0) begin
          nxt_st.skip_cnt = st_ff.skip_cnt - vscr_pkg::SKIP_CNT_W'(1);
        end else if (ev.bus_quiet) begin
          nxt_st.skip     = vscr_pkg::SK_OFF; // R23
          nxt_st.ctrl.nxt = 1'b0;
        end else begin
          nxt_st.skip = vscr_pkg::SK_WAIT;
        end
      end
      vscr_pkg::SK_WAIT: begin
        // bus activity ignored until a fresh idle
        if (ev.idle_start) begin
          nxt_st.skip     = vscr_pkg::SK_OFF; // R23
          nxt_st.ctrl.nxt = 1'b0;
        end
      end
      default: begin
        nxt_st.skip = vscr_pkg::SK_OFF;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff                 <= '0;
      st_ff.ctrl            <= vscr_pkg::vscr_ctrl_t'(vscr_pkg::CTRL_RESET); // R16
      st_ff.first_power_up_flag             <= 1'b1; // R7
      st_ff.win_open        <= 1'b1;
      st_ff.skip            <= vscr_pkg::SK_OFF;
      // idle bus reads high, so no false edge follows reset
      st_ff.bus_q           <= 2'h3;
      st_ff.bus_prev        <= 1'h1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  vscr_serial_shifter u_shifter (
    .clk       (clk),
    .rst       (rst),
    .tb_tick   (st_ff.tb_tick),
    .start     (xch_start),
    .tx_byte   (status_now),
    .sin_s     (st_ff.sin_q[1]),
    .busy      (sh_busy),
    .done      (sh_done),
    .rx_byte   (rx_byte),
    .sck       (sck),
    .sck_oe_n  (sck_oe_n),
    .sout      (sout),
    .sout_oe_n (sout_oe_n),
    .sactive_n (sactive_n)
  );

  // a response needs the request bit; the multi-byte bit alone sends nothing
  assign lc.resp_enable     = st_ff.ctrl.ack & ~st_ff.resp_suspend; // R17 R20 R22
  assign lc.resp_append_crc = st_ff.ctrl.ack & st_ff.ctrl.multi_byte_response_flag; // R21
  assign lc.quad_speed_mode = st_ff.codec_quad;
  assign lc.skip_to_idle    = (st_ff.skip != vscr_pkg::SK_OFF); // R23
  assign lc.sleep_request   = st_ff.ctrl.pd;
  // frame logic stays passive until the divide has been set once
  assign lc.codec_hold      = ~st_ff.configured;
  assign lc.rdy_long        = st_ff.rdy_long;
  assign lc.tb_tick         = st_ff.tb_tick;

  assign link_status_byte   = status_now;
  assign link_control_byte  = st_ff.ctrl;

endmodule // vscr_regs
`default_nettype wire

// ### rtl/vscr_pkg.sv
// shared constants and carrier types of the status/control register pair
package vscr_pkg;

  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned CLK_PER_US    = CLK_HZ / 1_000_000;
  localparam int unsigned SKIP_HOLD_NS  = 6000;
  localparam int unsigned SKIP_HOLD_CYC = (SKIP_HOLD_NS * CLK_PER_US + 999) / 1000;
  localparam int unsigned RESP_WIN_US   = 135;
  localparam int unsigned RESP_WIN_CYC  = RESP_WIN_US * CLK_PER_US;
  localparam int unsigned SKIP_CNT_W    = 11;
  localparam int unsigned RESP_CNT_W    = 15;
  localparam logic [3:0]  XFER_BITS     = 4'h8;
  localparam logic [4:0]  RESET_DIV     = 5'h10;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;

  // control byte, bit 7 first
  typedef struct packed {
    logic       ack;
    logic       multi_byte_response_flag;
    logic       nxt;
    logic       pd;
    logic       quad;
    logic [2:0] ds;
  } vscr_ctrl_t;

  // status byte, bit 7 first
  typedef struct packed {
    logic end_of_data_flag;
    logic multi_byte_response_flag;
    logic unused;
    logic first_power_up_flag;
    logic quad;
    logic crc;
    logic err;
    logic break_flag;
  } vscr_stat_t;

  // events and levels from the frame state machine and codec, same clock
  typedef struct packed {
    logic data_xfer_start;
    logic data_xfer_done;
    logic data_xfer_busy;
    logic xfer_is_ifr;
    logic xfer_first_of_frame;
    logic long_nb_after_eod;
    logic crc_error;
    logic symbol_error;
    logic short_byte;
    logic frame_width_error;
    logic echo_fail;
    logic host_late_start;
    logic missing_long_rdy;
    logic break_symbol;
    logic idle_start;
    logic idle_pin_low;
    logic bus_quiet;
    logic resp_tx_start;
    logic resp_tx_ok;
    logic resp_arb_lost;
    logic crc_byte_done;
  } vscr_link_ev_t;

  // steering towards the frame state machine and codec
  typedef struct packed {
    logic resp_enable;
    logic resp_append_crc;
    logic quad_speed_mode;
    logic skip_to_idle;
    logic sleep_request;
    logic codec_hold;
    logic rdy_long;
    logic tb_tick;
  } vscr_link_ctl_t;

  typedef enum logic [2:0] {SH_IDLE, SH_LEAD, SH_HIGH, SH_LOW, SH_LAG} vscr_sh_state_t;

  typedef struct packed {
    vscr_sh_state_t state;
    logic [7:0]     sh;
    logic [3:0]     cnt;
    logic           sck;
    logic           sout;
    logic           act;
    logic           done;
  } vscr_sh_st_t;

  typedef enum logic [1:0] {SK_OFF, SK_HOLD, SK_WAIT} vscr_skip_t;

  typedef struct packed {
    logic [1:0]            stat_q;
    logic [1:0]            rdy_q;
    logic [1:0]            bus_q;
    logic [1:0]            sin_q;
    logic                  stat_prev;
    logic                  bus_prev;
    vscr_ctrl_t            ctrl;
    logic                  end_of_data_flag;
    logic                  multi_byte_response_flag;
    logic                  first_power_up_flag;
    logic                  crc;
    logic                  err;
    logic                  break_flag;
    logic                  brk_armed;
    logic                  codec_quad;
    logic                  pend;
    logic                  xch_active;
    vscr_stat_t            snap;
    logic                  configured;
    logic                  resp_tx_seen;
    logic                  resp_suspend;
    logic                  win_open;
    logic [RESP_CNT_W-1:0] win_cnt;
    vscr_skip_t            skip;
    logic [SKIP_CNT_W-1:0] skip_cnt;
    logic [4:0]            div_cnt;
    logic                  tb_tick;
    logic                  rdy_long;
  } vscr_regs_st_t;

  // divide-by for each divide select, giving the 2 MHz time base
  function automatic logic [4:0] vscr_div_value(input logic [2:0] sel);
    logic [4:0] d;
    d = 5'h01;
    unique case (sel)
      3'h0: d = 5'h0c;
      3'h1: d = 5'h06;
      3'h2: d = 5'h0a;
      3'h3: d = 5'h05;
      3'h4: d = 5'h08;
      3'h5: d = 5'h04;
      3'h6: d = 5'h02;
      3'h7: d = 5'h01;
    endcase
    return d;
  endfunction

endpackage

// ### rtl/vscr_serial_shifter.sv
// serial byte exchange master: eight clocks, msb first
`timescale 1ns/1ps
`default_nettype none
module vscr_serial_shifter (
  input  wire  logic       clk,
  input  wire  logic       rst,
  input  wire  logic       tb_tick,
  input  wire  logic       start,
  input  wire  logic [7:0] tx_byte,
  input  wire  logic       sin_s,
  output logic             busy,
  output logic             done,
  output logic [7:0]       rx_byte,
  output logic             sck,
  output logic             sck_oe_n,
  output logic             sout,
  output logic             sout_oe_n,
  output logic             sactive_n
);

  vscr_pkg::vscr_sh_st_t st_ff;
  vscr_pkg::vscr_sh_st_t nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.done = 1'b0;
    unique case (st_ff.state)
      vscr_pkg::SH_IDLE: begin
        if (start) begin
          nxt_st.sh    = tx_byte;
          nxt_st.cnt   = 4'h0;
          nxt_st.act   = 1'b1;
          nxt_st.state = vscr_pkg::SH_LEAD;
        end
      end
      vscr_pkg::SH_LEAD: begin
        // one time-base step of lead before the first clock
        if (tb_tick) begin
          nxt_st.sck   = 1'b1;
          nxt_st.sout  = st_ff.sh[7]; // R2
          nxt_st.state = vscr_pkg::SH_HIGH;
        end
      end
      vscr_pkg::SH_HIGH: begin
        if (tb_tick) begin
          nxt_st.sck   = 1'b0;
          nxt_st.sh    = {st_ff.sh[6:0], sin_s}; // R2
          nxt_st.cnt   = st_ff.cnt + 4'h1;
          nxt_st.state = vscr_pkg::SH_LOW;
        end
      end
      vscr_pkg::SH_LOW: begin
        if (tb_tick) begin
          if (st_ff.cnt == vscr_pkg::XFER_BITS) begin // R2
            nxt_st.state = vscr_pkg::SH_LAG;
          end else begin
            nxt_st.sck   = 1'b1;
            nxt_st.sout  = st_ff.sh[7];
            nxt_st.state = vscr_pkg::SH_HIGH;
          end
        end
      end
      vscr_pkg::SH_LAG: begin
        if (tb_tick) begin
          nxt_st.act   = 1'b0;
          nxt_st.sout  = 1'b0;
          nxt_st.done  = 1'b1;
          nxt_st.state = vscr_pkg::SH_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '{state: vscr_pkg::SH_IDLE, sh: 8'h00, cnt: 4'h0, sck: 1'b0,
                 sout: 1'b0, act: 1'b0, done: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign busy      = (st_ff.state != vscr_pkg::SH_IDLE);
  assign done      = st_ff.done;
  assign rx_byte   = st_ff.sh;
  assign sck       = st_ff.sck;
  assign sout      = st_ff.sout;
  // pins float outside an exchange so other serial devices may use the bus
  assign sck_oe_n  = ~st_ff.act;
  assign sout_oe_n = ~st_ff.act;
  assign sactive_n = ~st_ff.act;

endmodule // vscr_serial_shifter
`default_nettype wire

// ### sim/vscr_regs_properties.sv
// port assertions for the status/control register pair
`timescale 1ns/1ps
`default_nettype none
module vscr_regs_properties #(
  parameter int unsigned RESP_WIN_CYCLES = 50
) (
  input wire logic                     clk,
  input wire logic                     rst,
  input wire logic                     stat_req,
  input wire vscr_pkg::vscr_link_ev_t  ev,
  input wire vscr_pkg::vscr_link_ctl_t lc,
  input wire vscr_pkg::vscr_stat_t     link_status_byte,
  input wire vscr_pkg::vscr_ctrl_t     link_control_byte,
  input wire logic                     sck,
  input wire logic                     sck_oe_n,
  input wire logic                     sout_oe_n,
  input wire logic                     sactive_n
);
  logic [3:0] rise_ff;
  logic       sck_ff;
  logic       fault;
  // every non-crc fault event except a status request while busy lands on the error flag
  assign fault = ev.symbol_error | ev.short_byte | ev.frame_width_error | ev.echo_fail
               | ev.host_late_start | ev.missing_long_rdy;
  // sck rises within the running exchange
  always_ff @(posedge clk) begin
    sck_ff <= sck;
    if (rst || sactive_n) begin
      rise_ff <= 4'h0;
    end else if (sck && !sck_ff) begin
      rise_ff <= rise_ff + 4'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_bit5_zero: assert property (link_status_byte.unused == 1'b0)
    else $error("status bit 5 set");
  chk_quad_mirror: assert property (link_status_byte.quad == link_control_byte.quad)
    else $error("quad status differs from control");
  chk_pins_released: assert property (sactive_n |-> sck_oe_n && sout_oe_n && !sck)
    else $error("serial pins driven outside exchange");
  chk_eight_clocks: assert property ($rose(sactive_n) |-> rise_ff == 4'h8)
    else $error("exchange without eight clocks");
  chk_stat_start: assert property ($rose(stat_req) && sactive_n && !ev.data_xfer_busy
    |-> ##[1:12] !sactive_n)
    else $error("status request not served");
  chk_ftu_drop: assert property ($rose(sactive_n) |-> ##[0:2] !link_status_byte.first_power_up_flag)
    else $error("first-up flag kept after exchange");
  chk_ftu_stays: assert property (!link_status_byte.first_power_up_flag |=> !link_status_byte.first_power_up_flag)
    else $error("first-up flag came back");
  chk_crc_set: assert property (ev.crc_error |=> link_status_byte.crc)
    else $error("crc flag not set");
  chk_err_set: assert property (fault |=> link_status_byte.err)
    else $error("error flag not set");
  chk_eod_cause: assert property ($rose(link_status_byte.end_of_data_flag)
    |-> $past(ev.data_xfer_start) && $past(ev.xfer_is_ifr))
    else $error("end-of-data flag without ifr transfer");
  chk_multi_byte_response_flag_cause: assert property ($rose(link_status_byte.multi_byte_response_flag)
    |-> $past(ev.data_xfer_done) || $past(ev.long_nb_after_eod))
    else $error("multi-byte status set without transfer");
  chk_brk_quad: assert property ($rose(link_status_byte.break_flag)
    |-> ##[0:1] !link_control_byte.quad)
    else $error("break left quad set");
  cov_exchange: cover property ($fell(sactive_n));
  cov_break: cover property ($rose(link_status_byte.break_flag));
  cov_skip: cover property ($rose(lc.skip_to_idle));
endmodule // vscr_regs_properties
bind vscr_regs vscr_regs_properties #(.RESP_WIN_CYCLES(RESP_WIN_CYCLES)) u_props (
  .clk(clk), .rst(rst), .stat_req(stat_req), .ev(ev), .lc(lc),
  .link_status_byte(link_status_byte), .link_control_byte(link_control_byte),
  .sck(sck), .sck_oe_n(sck_oe_n), .sout_oe_n(sout_oe_n), .sactive_n(sactive_n));
`default_nettype wire

// ### sim/vscr_host.sv
// host model: serial slave swapping its control byte for status
`timescale 1ns/1ps
`default_nettype none
module vscr_host (
  input  wire logic clk,
  input  wire logic sck,
  input  wire logic sout,
  input  wire logic sactive_n,
  output var  logic stat_req,
  output var  logic sin
);
  initial begin
    stat_req = 1'b0;
    sin = 1'b0;
  end
  // sin has no pull, so a released line shows the inverse level
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    @(negedge clk) stat_req = 1'b1;
    for (int k = 0; k < 400 && sactive_n; k++) @(negedge clk);
    for (int b = 7; b >= 0; b--) begin
      for (int k = 0; k < 40 && !sck; k++) @(negedge clk);
      sin = tx[b];
      for (int k = 0; k < 40 && sck; k++) @(negedge clk);
      rx[b] = sout;
    end
    for (int k = 0; k < 40 && !sactive_n; k++) @(negedge clk);
    stat_req = 1'b0;
    sin = ~sin;
  endtask
endmodule // vscr_host
`default_nettype wire

// ### sim/tb_top.sv
// testbench: host swaps, link events and flag checks
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, rst, rdy, bus, stat_req, sin, sck, sout, sck_oe_n, sout_oe_n, sact_n;
  logic                     sck_pin;
  logic                     sout_pin;
  logic [7:0]               st;
  logic [7:0]               e;
  vscr_pkg::vscr_link_ev_t  ev;
  vscr_pkg::vscr_link_ev_t  m;
  vscr_pkg::vscr_link_ctl_t lc;
  vscr_pkg::vscr_stat_t     stb;
  vscr_pkg::vscr_ctrl_t     ctb;
  int                       fail_count = 0;
  int                       num_checks = 0;
  int                       n;
  // pull-downs hold the released serial pins low
  assign sck_pin = sck_oe_n ? 1'b0 : sck;
  assign sout_pin = sout_oe_n ? 1'b0 : sout;
  vscr_regs #(.RESP_WIN_CYCLES(50)) uut (
    .clk(clk), .rst(rst), .stat_req(stat_req), .rdy(rdy), .bus_symbol_in(bus),
    .sin(sin), .ev(ev), .lc(lc), .link_status_byte(stb), .link_control_byte(ctb),
    .sck(sck), .sck_oe_n(sck_oe_n), .sout(sout), .sout_oe_n(sout_oe_n), .sactive_n(sact_n));
  vscr_host host (.clk(clk), .sck(sck_pin), .sout(sout_pin), .sactive_n(sact_n),
    .stat_req(stat_req), .sin(sin));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic swap(input logic [7:0] tx);
    host.xfer(tx, st);
    repeat (2) @(negedge clk);
  endtask
  task automatic pulse(input vscr_pkg::vscr_link_ev_t p);
    @(negedge clk) ev = vscr_pkg::vscr_link_ev_t'(ev | p);
    @(negedge clk) ev = vscr_pkg::vscr_link_ev_t'(ev & ~p);
    repeat (2) @(negedge clk);
  endtask
  task automatic bus_to(input logic v);
    @(negedge clk) bus = v;
    repeat (6) @(negedge clk);
  endtask
  // clocks between two time-base ticks
  task automatic gap(input int exp);
    for (int k = 0; k < 40 && !lc.tb_tick; k++) @(negedge clk);
    @(negedge clk);
    n = 1;
    while (!lc.tb_tick && n < 40) begin
      @(negedge clk);
      n++;
    end
    check(8'(n), 8'(exp));
  endtask
  initial begin
    rst = 1'b1;
    rdy = 1'b0;
    bus = 1'b1;
    ev = '{bus_quiet: 1'b1, default: 1'b0};
    repeat (16) @(negedge clk);
    rst = 1'b0;
    check(stb, 8'h10);
    check(ctb, 8'h00);
    check(lc.codec_hold, 1'b1);
    gap(16);
    swap(8'h0c);
    check(st, 8'h10);
    check(ctb, 8'h0c);
    check(lc.codec_hold, 1'b0);
    check(stb, 8'h08);
    check(lc.quad_speed_mode, 1'b0);
    gap(8);
    bus_to(1'b0);
    check(lc.quad_speed_mode, 1'b1);
    bus_to(1'b1);
    // crc_error down to missing_long_rdy sit side by side in the struct
    for (int k = 0; k < 7; k++) begin
      m = '0;
      m[14-k] = 1'b1;
      pulse(m);
      e = (k == 0) ? 8'h0c : 8'h0a;
      check(stb, e);
      swap(8'h0c);
      check(st, e);
      check(stb, 8'h08);
    end
    ev.data_xfer_busy = 1'b1;
    fork
      swap(8'h0c);
      begin
        repeat (30) @(negedge clk);
        ev.data_xfer_busy = 1'b0;
      end
    join
    check(st, 8'h0a);
    pulse('{break_symbol: 1'b1, default: 1'b0});
    bus_to(1'b0);
    bus_to(1'b1);
    check(stb, 8'h01);
    ev.idle_pin_low = 1'b1;
    swap(8'h0c);
    check(st, 8'h01);
    check(ctb, 8'h04);
    pulse('{data_xfer_start: 1'b1, xfer_is_ifr: 1'b1, default: 1'b0});
    check(stb, 8'h80);
    swap(8'hc4);
    check(ctb, 8'hc4);
    check(stb, 8'h80);
    check({lc.resp_enable, lc.resp_append_crc}, 2'b11);
    rdy = 1'b1;
    repeat (3) @(negedge clk);
    pulse('{data_xfer_done: 1'b1, default: 1'b0});
    check(stb, 8'hc0);
    check(lc.rdy_long, 1'b1);
    rdy = 1'b0;
    pulse('{resp_tx_start: 1'b1, resp_arb_lost: 1'b1, default: 1'b0});
    check(lc.resp_enable, 1'b0);
    pulse('{resp_tx_ok: 1'b1, default: 1'b0});
    check(ctb, 8'h44);
    pulse('{idle_start: 1'b1, default: 1'b0});
    check(ctb, 8'h04);
    pulse('{data_xfer_start: 1'b1, xfer_is_ifr: 1'b1, default: 1'b0});
    ev.idle_pin_low = 1'b0;
    pulse('{crc_byte_done: 1'b1, default: 1'b0});
    repeat (60) @(negedge clk);
    swap(8'h84);
    check(ctb, 8'h04);
    pulse('{data_xfer_start: 1'b1, xfer_first_of_frame: 1'b1, default: 1'b0});
    check(stb, 8'h00);
    swap(8'h24);
    check(lc.skip_to_idle, 1'b1);
    repeat (vscr_pkg::SKIP_HOLD_CYC - 20) @(negedge clk);
    check(lc.skip_to_idle, 1'b1);
    repeat (40) @(negedge clk);
    check(lc.skip_to_idle, 1'b0);
    check(ctb, 8'h04);
    swap(8'h14);
    check(ctb, 8'h14);
    check(lc.sleep_request, 1'b1);
    rdy = 1'b1;
    repeat (4) @(negedge clk);
    check(lc.sleep_request, 1'b0);
    rdy = 1'b0;
    repeat (3) @(negedge clk);
    pulse('{data_xfer_done: 1'b1, default: 1'b0});
    check(lc.rdy_long, 1'b0);
    stop_test();
  end
  // cut a hang short well past the expected few thousand cycles
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
